// >>> rtl/ffss_axil_regs.v
// AXI4-Lite register slave for sequencer state; only the status run-enable bit is writable
`include "ffss_defs.vh"

module ffss_axil_regs (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Write channels
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // Read channels
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Block state
  input wire [31:0] statusWord,
  input wire [31:0] frameWord,
  input wire [31:0] nextWord,
  input wire [31:0] sliceWord,
  // Software run enable
  output reg runEn_q
);

  reg awHave_q;
  reg wHave_q;
  reg [3:0] awAddr_q;
  reg [31:0] wData_q;
  reg wLane0_q;
  wire doWrite;

  assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;

  // Write path: address and data latched in either order
  always @(posedge ref_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 4'h0;
      wData_q <= 32'h0000_0000;
      wLane0_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FFSS_RESP_OKAY;
      runEn_q <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wLane0_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Only the status word holds a writable bit
        if (awAddr_q == `FFSS_REG_STATUS) begin
          s_axi_bresp <= `FFSS_RESP_OKAY;
          if (wLane0_q) begin
            runEn_q <= wData_q[`FFSS_ST_RUN_EN];
          end
        end else if (awAddr_q == `FFSS_REG_FRAME ||
                     awAddr_q == `FFSS_REG_NEXT ||
                     awAddr_q == `FFSS_REG_SLICE) begin
          s_axi_bresp <= `FFSS_RESP_OKAY;
        end else begin
          s_axi_bresp <= `FFSS_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read path: one outstanding read, answer one cycle after address
  always @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `FFSS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `FFSS_RESP_OKAY;
      case (s_axi_araddr)
        `FFSS_REG_STATUS: s_axi_rdata <= statusWord;
        `FFSS_REG_FRAME: s_axi_rdata <= frameWord;
        `FFSS_REG_NEXT: s_axi_rdata <= nextWord;
        `FFSS_REG_SLICE: s_axi_rdata <= sliceWord;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `FFSS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// >>> rtl/ffss_defs.vh
// Constants for the frame and slice sequencer
`ifndef FFSS_DEFS_VH
`define FFSS_DEFS_VH

// Command codes on the synchronous command port
`define FFSS_CMD_NONE 2'h0
`define FFSS_CMD_SET_NEXT 2'h1
`define FFSS_CMD_FRAME 2'h2
`define FFSS_CMD_SLICE 2'h3

// Timing method encodings
`define FFSS_COUNTER_RESET_TIMING 1'b0
`define FFSS_SLICE_START_MEASURE_TIMING 1'b1

// Field widths
`define FFSS_FRAME_W 32
`define FFSS_SLICE_W 16
`define FFSS_TIME_W 16

// Reset values
`define FFSS_FRAME_RST 32'h0000_0000
`define FFSS_SLICE_RST 16'h0000
`define FFSS_TIME_RST 16'h0000

// Cycles from a frame command to counter zero (fixed per design)
`define FFSS_SYNC_RST_CYCLES 2'h1

// AXI4-Lite register byte offsets
`define FFSS_REG_STATUS 4'h0
`define FFSS_REG_FRAME 4'h4
`define FFSS_REG_NEXT 4'h8
`define FFSS_REG_SLICE 4'hc

// Status register bit positions
`define FFSS_ST_ACTIVE 0
`define FFSS_ST_NEXT_VALID 1
`define FFSS_ST_METHOD 2
`define FFSS_ST_RUN_EN 3

// AXI responses
`define FFSS_RESP_OKAY 2'h0
`define FFSS_RESP_SLVERR 2'h2

`endif

// >>> rtl/ffss_sequencer.v
// Frame and slice command sequencer for a front-end module
//
// Contract
// - frame start with pending number, counter-reset timing: zero time counters.
// - counter zeroing takes a fixed number of global clock cycles.
// - frame start, slice-measure timing: record internal time of that edge.
// - frame start with pending number copies it to current frame number.
// - frame start consumes pending number, marking it uninitialized.
// - frame start with pending number clears slice number.
// - inactive plus pending: go active, digitize, send when data ready. (Code digitizes only if the status run-enable bit is set.)
// - active without pending: go inactive, stop digitizing, keep sending.
// - inactive without pending: ignore frame command.
// - slice command acts only while frame active.
// - accepted slice: measure timing records time; counter-reset does nothing.
// - accepted slice increments slice number by one.
// - each hit yields time count, frame and slice numbers together.
// - slice-measure timing: counter rollover longer than a slice.
// - counter-reset timing: rollover at least one slice length.
// - slice number may lag high by one; rollover then two slices.
// - set-next command stores number and marks it initialized.
// - module reset ignores all commands; resume after release.
// - module reset stops digitizing, sending, drops data, clears state.
`include "ffss_defs.vh"

module ffss_sequencer #(
  // Timing method, fixed at build time
  parameter TIMING_METHOD = `FFSS_COUNTER_RESET_TIMING
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Module reset line from the concentrator
  input wire modRst,
  // Synchronous command port
  input wire cmdValid,
  input wire [1:0] cmdCode,
  input wire [31:0] cmdFrame,
  // Hit digitizer interface
  input wire hitValid,
  input wire txDataReady,
  // Tagged hit output
  output reg hitTagValid_q,
  output reg [15:0] hitTime_q,
  output reg [31:0] hitFrame_q,
  output reg [15:0] hitSlice_q,
  // Control outputs
  output reg digitizeEn_q,
  output reg transmitEn_q,
  output reg flushBuf_q,
  output reg frameActive_q,
  output reg [15:0] sliceStartTime_q,
  output reg sliceMark_q,
  // AXI4-Lite slave
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [31:0] nextFrame_q;
  reg nextValid_q;
  reg [31:0] frameNum_q;
  reg [15:0] sliceNum_q;
  reg pendSend_q;
  reg [1:0] zeroCnt_q;
  wire [15:0] timeCount;
  wire runEn;
  wire cmdLive;
  wire frameCmd;
  wire sliceCmd;
  wire setCmd;
  wire newFrame;
  wire zeroReq;
  wire [31:0] statusWord;
  localparam METHOD_MEASURE = (TIMING_METHOD ==
    `FFSS_SLICE_START_MEASURE_TIMING);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Module reset masks every command while held
  assign cmdLive = cmdValid && !modRst;
  assign setCmd = cmdLive && cmdCode == `FFSS_CMD_SET_NEXT;
  assign frameCmd = cmdLive && cmdCode == `FFSS_CMD_FRAME;
  assign sliceCmd = cmdLive && cmdCode == `FFSS_CMD_SLICE &&
    frameActive_q;
  assign newFrame = frameCmd && nextValid_q;

  // Counter-reset timing zeroes the time base on every new frame
  assign zeroReq = !METHOD_MEASURE && newFrame;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  // 16-bit rollover; the rollover must span at least two slices for
  // late slice tagging to be resolvable downstream
  ffss_time_counter uTime (
    .ref_clk(ref_clk),
    .rst(rst),
    .zeroReq(zeroReq),
    .count_q(timeCount)
  );

  // Fixed latency marker from the frame command to counter zero
  always @(posedge ref_clk) begin
    if (rst) begin
      zeroCnt_q <= 2'h0;
    end else if (zeroReq) begin
      zeroCnt_q <= `FFSS_SYNC_RST_CYCLES;
    end else if (zeroCnt_q != 2'h0) begin
      zeroCnt_q <= zeroCnt_q - 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Frame and slice state
  // ----------------------------------------------------------------
  // Set-next and frame commands never share a cycle, so order is moot
  always @(posedge ref_clk) begin
    if (rst || modRst) begin
      nextFrame_q <= `FFSS_FRAME_RST;
      nextValid_q <= 1'b0;
      frameActive_q <= 1'b0;
      frameNum_q <= `FFSS_FRAME_RST;
      sliceNum_q <= `FFSS_SLICE_RST;
      sliceStartTime_q <= `FFSS_TIME_RST;
      sliceMark_q <= 1'b0;
    end else begin
      sliceMark_q <= 1'b0;
      if (setCmd) begin
        nextFrame_q <= cmdFrame;
        nextValid_q <= 1'b1;
      end
      if (newFrame) begin
        frameNum_q <= nextFrame_q;
        nextValid_q <= 1'b0;
        sliceNum_q <= `FFSS_SLICE_RST;
        frameActive_q <= 1'b1;
        sliceMark_q <= 1'b1;
        if (METHOD_MEASURE) begin
          sliceStartTime_q <= timeCount;
        end
      end else if (frameCmd && frameActive_q) begin
        frameActive_q <= 1'b0;
      end else if (sliceCmd) begin
        sliceNum_q <= sliceNum_q + 16'h0001;
        sliceMark_q <= 1'b1;
        if (METHOD_MEASURE) begin
          sliceStartTime_q <= timeCount;
        end
      end
      // Inactive frame and no pending number: command dropped
    end
  end

  // ----------------------------------------------------------------
  // Digitizing and transmission control
  // ----------------------------------------------------------------
  // Transmission keeps draining after a frame stops; only the module
  // reset or rst halts it and flushes unsent data
  always @(posedge ref_clk) begin
    if (rst || modRst) begin
      digitizeEn_q <= 1'b0;
      transmitEn_q <= 1'b0;
      flushBuf_q <= 1'b1;
      pendSend_q <= 1'b0;
    end else begin
      flushBuf_q <= 1'b0;
      if (newFrame && !frameActive_q) begin
        digitizeEn_q <= runEn;
        pendSend_q <= 1'b1;
      end else if (frameCmd && !nextValid_q && frameActive_q) begin
        digitizeEn_q <= 1'b0;
      end
      if (pendSend_q && txDataReady) begin
        transmitEn_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Hit tagging
  // ----------------------------------------------------------------
  // Time, frame and slice captured in one cycle so they agree
  always @(posedge ref_clk) begin
    if (rst || modRst) begin
      hitTagValid_q <= 1'b0;
      hitTime_q <= `FFSS_TIME_RST;
      hitFrame_q <= `FFSS_FRAME_RST;
      hitSlice_q <= `FFSS_SLICE_RST;
    end else begin
      hitTagValid_q <= hitValid && digitizeEn_q;
      if (hitValid && digitizeEn_q) begin
        hitTime_q <= timeCount;
        hitFrame_q <= frameNum_q;
        hitSlice_q <= sliceNum_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  assign statusWord = {28'h000_0000, runEn, METHOD_MEASURE ? 1'b1 : 1'b0,
    nextValid_q, frameActive_q};

  ffss_axil_regs uRegs (
    .ref_clk(ref_clk),
    .rst(rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .statusWord(statusWord),
    .frameWord(frameNum_q),
    .nextWord(nextFrame_q),
    .sliceWord({16'h0000, sliceNum_q}),
    .runEn_q(runEn)
  );

endmodule

// >>> rtl/ffss_time_counter.v
// Internal free-running time counter with synchronous zeroing
`include "ffss_defs.vh"

module ffss_time_counter (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Control
  input wire zeroReq,
  // Count
  output reg [`FFSS_TIME_W-1:0] count_q
);

  // Rollover counter; zeroing wins over counting so time zero is exact
  always @(posedge ref_clk) begin
    if (rst || zeroReq) begin
      count_q <= `FFSS_TIME_RST;
    end else begin
      count_q <= count_q + 16'h0001;
    end
  end

endmodule

// >>> tb/ffss_cmd_source.sv
// Concentrator model issuing synchronous commands
`include "ffss_defs.vh"
module ffss_cmd_source (
  // Clock
  input wire ref_clk,
  // Command port
  output logic cmdValid,
  output logic [1:0] cmdCode,
  output logic [31:0] cmdFrame
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmdValid = 1'b0;
    cmdCode = `FFSS_CMD_NONE;
    cmdFrame = 32'hA5A5_5A5A;
  end
  // Issue n identical commands on consecutive cycles
  task send(input logic [1:0] c, input logic [31:0] f, input int n);
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdCode <= c;
    cmdFrame <= f;
    repeat (n) @(posedge ref_clk);
    cmdValid <= 1'b0;
    cmdCode <= `FFSS_CMD_NONE;
    // Released lines change, so a stale number cannot pass
    cmdFrame <= ~f;
  endtask
endmodule

// >>> tb/ffss_seq_asserts.sv
// Checker for the frame and slice sequencer ports
`include "ffss_defs.vh"
module ffss_seq_asserts #(
  parameter TIMING_METHOD = 0
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Commands and hits
  input wire modRst,
  input wire cmdValid,
  input wire [1:0] cmdCode,
  input wire hitValid,
  // Observed state
  input wire hitTagValid_q,
  input wire [15:0] hitTime_q,
  input wire [15:0] hitSlice_q,
  input wire digitizeEn_q,
  input wire transmitEn_q,
  input wire flushBuf_q,
  input wire frameActive_q,
  input wire sliceMark_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire live = cmdValid && !modRst;
  wire isFrame = live && cmdCode == `FFSS_CMD_FRAME;
  wire isSlice = live && cmdCode == `FFSS_CMD_SLICE;
  wire isNext = live && cmdCode == `FFSS_CMD_SET_NEXT;
  reg pend_q;
  // Pending number shadow, since next-valid is not a port
  always @(posedge ref_clk)
    if (rst || modRst) pend_q <= 1'b0;
    else if (isNext) pend_q <= 1'b1;
    else if (isFrame) pend_q <= 1'b0;
  // ----------------------------------------
  // Frame and slice commands
  // ----------------------------------------
  sequence s_frameGo;
    isFrame && pend_q ##1 hitValid && digitizeEn_q && !cmdValid && !modRst;
  endsequence
  property p_start;
    isFrame && !frameActive_q && pend_q |=> frameActive_q && sliceMark_q;
  endproperty
  a_start: assert property (p_start) else $error("frame did not start");
  property p_stop;
    isFrame && frameActive_q && !pend_q |=> !frameActive_q && !digitizeEn_q;
  endproperty
  a_stop: assert property (p_stop) else $error("frame did not stop");
  property p_idle;
    isFrame && !frameActive_q && !pend_q |=> !frameActive_q && !sliceMark_q;
  endproperty
  a_idle: assert property (p_idle) else $error("idle frame acted");
  property p_sliceOff;
    isSlice && !frameActive_q |=> !sliceMark_q;
  endproperty
  a_sliceOff: assert property (p_sliceOff) else $error("slice taken");
  property p_sliceOn;
    isSlice && frameActive_q |=> sliceMark_q;
  endproperty
  a_sliceOn: assert property (p_sliceOn) else $error("slice lost");
  property p_sliceZero;
    s_frameGo |=> hitSlice_q == 16'h0000;
  endproperty
  a_sliceZero: assert property (p_sliceZero) else $error("slice kept");
  property p_timeZero;
    TIMING_METHOD == 0 ##0 s_frameGo |=> hitTime_q == 16'h0000;
  endproperty
  a_timeZero: assert property (p_timeZero) else $error("time kept");
  property p_hitTag;
    hitValid && digitizeEn_q && !modRst |=> hitTagValid_q;
  endproperty
  a_hitTag: assert property (p_hitTag) else $error("hit untagged");
  // ----------------------------------------
  // Module reset
  // ----------------------------------------
  property p_modRst;
    modRst |=> !frameActive_q && !digitizeEn_q && !transmitEn_q && flushBuf_q;
  endproperty
  a_modRst: assert property (p_modRst) else $error("reset left state");
  property p_mask;
    modRst |=> !sliceMark_q;
  endproperty
  a_mask: assert property (p_mask) else $error("command in reset");
endmodule

// >>> tb/ffss_sequencer_tb.sv
// Testbench for the frame and slice sequencer
`include "ffss_defs.vh"
module ffss_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst = 1, modRst = 0, hitValid = 0, txDataReady = 0;
  logic cmdValid, hitTagValid_q, digitizeEn_q, transmitEn_q, flushBuf_q;
  logic frameActive_q, sliceMark_q;
  logic [1:0] cmdCode;
  logic [31:0] cmdFrame, hitFrame_q, rd;
  logic [15:0] hitTime_q, hitSlice_q, sliceStartTime_q;
  logic [15:0] mTime, mStart;
  logic [3:0] s_axi_awaddr = 0, s_axi_wstrb = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int miscompares = 0, testsRun = 0;
  always #25 ref_clk = ~ref_clk;
  ffss_cmd_source src (.ref_clk, .cmdValid, .cmdCode, .cmdFrame);
  ffss_sequencer #(.TIMING_METHOD(0)) DUT (.ref_clk, .rst, .modRst,
    .cmdValid, .cmdCode, .cmdFrame, .hitValid, .txDataReady, .hitTagValid_q,
    .hitTime_q, .hitFrame_q, .hitSlice_q, .digitizeEn_q, .transmitEn_q,
    .flushBuf_q, .frameActive_q, .sliceStartTime_q, .sliceMark_q,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // Slice-measure build on the same stimulus; only its times are judged
  ffss_sequencer #(.TIMING_METHOD(1)) DUT_M (.ref_clk, .rst, .modRst,
    .cmdValid, .cmdCode, .cmdFrame, .hitValid, .txDataReady,
    .hitTagValid_q(), .hitTime_q(mTime), .hitFrame_q(), .hitSlice_q(),
    .digitizeEn_q(), .transmitEn_q(), .flushBuf_q(), .frameActive_q(),
    .sliceStartTime_q(mStart), .sliceMark_q(), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready);
  // ----------------------------------------
  // Reporting
  // ----------------------------------------
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task tmo(input int n);
    if (n >= 50) begin
      miscompares++;
      conclude();
    end
  endtask
  // ----------------------------------------
  // Bus cycles, held until the slave answers
  // ----------------------------------------
  task wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    logic aw, w;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    aw = 0;
    w = 0;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready && !aw) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wready && !w) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end while (!(aw && w) && n < 50);
    tmo(n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!s_axi_bvalid && n < 50);
    tmo(n);
    check("bresp", s_axi_bresp, `FFSS_RESP_OKAY);
    s_axi_bready <= 0;
  endtask
  task rdReg(input logic [3:0] a, input logic [1:0] resp);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!s_axi_rvalid && n < 50);
    tmo(n);
    rd = s_axi_rdata;
    check("rresp", s_axi_rresp, resp);
    s_axi_rready <= 0;
  endtask
  task pulse;
    @(posedge ref_clk);
    hitValid <= 1;
    @(posedge ref_clk);
    hitValid <= 0;
    #1;
  endtask
  task cmd(input logic [1:0] c, input logic [31:0] f);
    src.send(c, f, 1);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    rdReg(`FFSS_REG_STATUS, `FFSS_RESP_OKAY);
    check("status", rd, 32'h0000_0008);
    rdReg(4'h2, `FFSS_RESP_SLVERR);
    check("unmapped", rd, 32'h0000_0000);
    wr(`FFSS_REG_STATUS, 32'h0000_0000);
    cmd(`FFSS_CMD_SET_NEXT, 32'h0000_0003);
    cmd(`FFSS_CMD_FRAME, 0);
    check("gated", digitizeEn_q, 1'b0);
    cmd(`FFSS_CMD_FRAME, 0);
    wr(`FFSS_REG_STATUS, 32'h0000_0008);
    $display("test regs done");
  endtask
  task t_start;
    cmd(`FFSS_CMD_SET_NEXT, 32'h0000_0005);
    cmd(`FFSS_CMD_FRAME, 0);
    check("active", frameActive_q, 1'b1);
    check("digitize", digitizeEn_q, 1'b1);
    @(posedge ref_clk);
    txDataReady <= 1;
    pulse();
    check("tag", hitTagValid_q, 1'b1);
    check("frame", hitFrame_q, 32'h0000_0005);
    check("slice", hitSlice_q, 16'h0000);
    check("send", transmitEn_q, 1'b1);
    check("mFrame", 16'(mTime - mStart), 32'h0000_0003);
    rdReg(`FFSS_REG_STATUS, `FFSS_RESP_OKAY);
    check("consumed", rd, 32'h0000_0009);
    src.send(`FFSS_CMD_SLICE, 0, 3);
    pulse();
    check("slice3", hitSlice_q, 16'h0003);
    check("noMeasure", sliceStartTime_q, 32'h0000_0000);
    check("mSlice", 16'(mTime - mStart), 32'h0000_0002);
    $display("test start done");
  endtask
  task t_stop;
    cmd(`FFSS_CMD_FRAME, 0);
    check("inactive", frameActive_q, 1'b0);
    check("nodig", digitizeEn_q, 1'b0);
    check("keepsend", transmitEn_q, 1'b1);
    cmd(`FFSS_CMD_SLICE, 0);
    cmd(`FFSS_CMD_FRAME, 0);
    rdReg(`FFSS_REG_SLICE, `FFSS_RESP_OKAY);
    check("sliceheld", rd, 32'h0000_0003);
    rdReg(`FFSS_REG_STATUS, `FFSS_RESP_OKAY);
    check("ignored", rd, 32'h0000_0008);
    $display("test stop done");
  endtask
  task t_modRst;
    cmd(`FFSS_CMD_SET_NEXT, 32'h0000_0007);
    cmd(`FFSS_CMD_FRAME, 0);
    @(posedge ref_clk);
    modRst <= 1;
    cmd(`FFSS_CMD_SET_NEXT, 32'h0000_0009);
    check("flush", flushBuf_q, 1'b1);
    check("nosend", transmitEn_q, 1'b0);
    check("off", frameActive_q, 1'b0);
    @(posedge ref_clk);
    modRst <= 0;
    cmd(`FFSS_CMD_FRAME, 0);
    check("masked", frameActive_q, 1'b0);
    cmd(`FFSS_CMD_SET_NEXT, 32'h0000_0009);
    // Hit in the cycle right after the frame start sees time zero
    src.send(`FFSS_CMD_FRAME, 0, 1);
    hitValid <= 1;
    @(posedge ref_clk);
    hitValid <= 0;
    #1;
    check("resume", hitFrame_q, 32'h0000_0009);
    check("time0", hitTime_q, 32'h0000_0000);
    check("slice0", hitSlice_q, 32'h0000_0000);
    check("mResume", 16'(mTime - mStart), 32'h0000_0001);
    $display("test module reset done");
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 0;
    t_regs();
    t_start();
    t_stop();
    t_modRst();
    conclude();
  end
endmodule
bind ffss_sequencer ffss_seq_asserts #(.TIMING_METHOD(TIMING_METHOD)) chk (
  .ref_clk, .rst, .modRst, .cmdValid, .cmdCode, .hitValid, .hitTagValid_q,
  .hitTime_q, .hitSlice_q, .digitizeEn_q, .transmitEn_q, .flushBuf_q,
  .frameActive_q, .sliceMark_q);
